// File: hdl/vip_top.sv
// video input ports: parallel capture, channel remap, serial link crossing
`timescale 1ns/1ps
module vip_top
  import vip_pkg::*;
(
  input wire logic i_clk,                        // system clock, 40 MHz
  input wire logic i_rst_b,                      // async reset, active low
  input wire logic i_parallel_pixel_clock_a,     // parallel pixel clock A
  input wire logic i_parallel_vertical_sync,     // parallel vsync
  input wire logic i_parallel_horizontal_sync,   // parallel hsync
  input wire logic i_parallel_data_enable,       // parallel data enable
  input wire logic i_parallel_field_id,          // field, interlaced only
  input wire logic [VIP_CW-1:0] i_chan_a,        // channel A pixel bits
  input wire logic [VIP_CW-1:0] i_chan_b,        // channel B pixel bits
  input wire logic [VIP_CW-1:0] i_chan_c,        // channel C pixel bits
  input wire logic i_lvds_link_clock,            // serial link clock
  input wire logic [VIP_NLANE-1:0] i_lvds_lane,  // lanes A..E, received bits
  input wire logic [1:0] i_map_0,                // source channel for slot 0
  input wire logic [1:0] i_map_1,                // source channel for slot 1
  input wire logic [1:0] i_map_2,                // source channel for slot 2
  input wire logic [1:0] i_lvds_fmt,             // serial demap format
  input wire logic i_src_sel,                    // 0 parallel, 1 serial
  input wire logic i_par_src_sel,                // which shared parallel source
  output logic o_src0_hiz,                       // tri-state request, source 0
  output logic o_src1_hiz,                       // tri-state request, source 1
  output logic [VIP_PW-1:0] o_pix,               // active pixel word
  output logic o_pix_vld,                        // pixel strobe, system clock
  output logic o_vs,                             // vertical sync, system clock
  output logic o_hs,                             // horizontal sync
  output logic o_field,                          // field id
  output logic [VIP_CW-VIP_FRAC-1:0] o_int0      // integer part of slot 0
);
  // ==========================================================================
  // parallel port on clock A
  logic prst_m_r, prst_r, lrst_m_r, lrst_r;
  logic [VIP_PW-1:0] pin_r, pmap_r, pdat_r;
  logic pde_r, phs_r, pvs_r, pfld_r, ptgl_r, phs2_r, pvs2_r, pfld2_r;
  logic [1:0] pm0_m, pm0_s, pm1_m, pm1_s, pm2_m, pm2_s;
  logic [VIP_CW-1:0] slot [VIP_NCH];
  logic [VIP_CW-1:0] chn [VIP_NCH];

  // reset release synchronised into each link domain
  always_ff @(posedge i_parallel_pixel_clock_a or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prst_m_r <= 1'b0;
      prst_r <= 1'b0;
    end else begin
      prst_m_r <= 1'b1;
      prst_r <= prst_m_r;
    end
  end

  always_ff @(posedge i_lvds_link_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lrst_m_r <= 1'b0;
      lrst_r <= 1'b0;
    end else begin
      lrst_m_r <= 1'b1;
      lrst_r <= lrst_m_r;
    end
  end

  // remap select is quasi-static; still synchronised into clock A
  always_ff @(posedge i_parallel_pixel_clock_a or negedge prst_r) begin
    if (!prst_r) begin
      pm0_m <= VIP_SEL_A;
      pm0_s <= VIP_SEL_A;
      pm1_m <= VIP_SEL_B;
      pm1_s <= VIP_SEL_B;
      pm2_m <= VIP_SEL_C;
      pm2_s <= VIP_SEL_C;
    end else begin
      pm0_m <= i_map_0;
      pm0_s <= pm0_m;
      pm1_m <= i_map_1;
      pm1_s <= pm1_m;
      pm2_m <= i_map_2;
      pm2_s <= pm2_m;
    end
  end

  // input register: sync, enable, field and data all on clock A
  always_ff @(posedge i_parallel_pixel_clock_a or negedge prst_r) begin
    if (!prst_r) begin
      pin_r <= '0;
      pde_r <= 1'b0;
      phs_r <= 1'b0;
      pvs_r <= 1'b0;
      pfld_r <= 1'b0;
    end else begin
      pin_r <= {i_chan_c, i_chan_b, i_chan_a}; // R10 R1 R2 R3
      pde_r <= i_parallel_data_enable; // R10
      phs_r <= i_parallel_horizontal_sync; // R10
      pvs_r <= i_parallel_vertical_sync; // R10
      pfld_r <= i_parallel_field_id; // R10 R11
    end
  end

  assign chn[0] = pin_r[VIP_CW-1:0];
  assign chn[1] = pin_r[2*VIP_CW-1:VIP_CW];
  assign chn[2] = pin_r[3*VIP_CW-1:2*VIP_CW];

  // channel swap network, any channel to any slot
  always_comb begin
    slot[0] = (pm0_s == VIP_SEL_B) ? chn[1] : (pm0_s == VIP_SEL_C) ? chn[2] : chn[0]; // R4
    slot[1] = (pm1_s == VIP_SEL_A) ? chn[0] : (pm1_s == VIP_SEL_C) ? chn[2] : chn[1]; // R4
    slot[2] = (pm2_s == VIP_SEL_A) ? chn[0] : (pm2_s == VIP_SEL_B) ? chn[1] : chn[2]; // R4
    pmap_r = {slot[2], slot[1], slot[0]};
  end

  // hold qualified words; toggle marks each active pixel for the crossing
  always_ff @(posedge i_parallel_pixel_clock_a or negedge prst_r) begin
    if (!prst_r) begin
      pdat_r <= '0;
      ptgl_r <= 1'b0;
      phs2_r <= 1'b0;
      pvs2_r <= 1'b0;
      pfld2_r <= 1'b0;
    end else begin
      phs2_r <= phs_r;
      pvs2_r <= pvs_r;
      pfld2_r <= pfld_r;
      if (pde_r) begin
        pdat_r <= pmap_r; // R12
        ptgl_r <= ~ptgl_r; // R12
      end
    end
  end

  // ==========================================================================
  // serial port on the link clock
  logic [1:0] fmt_m_r, fmt_s_r;
  logic [VIP_PW-1:0] lpix;
  logic lde, lhs, lvs, ltgl;

  always_ff @(posedge i_lvds_link_clock or negedge lrst_r) begin
    if (!lrst_r) begin
      fmt_m_r <= '0;
      fmt_s_r <= '0;
    end else begin
      fmt_m_r <= i_lvds_fmt;
      fmt_s_r <= fmt_m_r; // R8
    end
  end

  // the link clock must stay within the 90 MHz effective rate; not checked
  vip_lvds_rx u_rx (
    .i_lclk(i_lvds_link_clock),
    .i_lrst_b(lrst_r),
    .i_lane(i_lvds_lane),
    .i_fmt(fmt_s_r),
    .o_pix(lpix),
    .o_de(lde),
    .o_hs(lhs),
    .o_vs(lvs),
    .o_tgl(ltgl)
  ); // R7 R9

  // serial word held for the crossing, toggle only when enabled
  logic [VIP_PW-1:0] ldat_r;
  logic ltgl_r, lprev_r, lhs_r, lvs_r;
  always_ff @(posedge i_lvds_link_clock or negedge lrst_r) begin
    if (!lrst_r) begin
      ldat_r <= '0;
      ltgl_r <= 1'b0;
      lprev_r <= 1'b0;
      lhs_r <= 1'b0;
      lvs_r <= 1'b0;
    end else begin
      lprev_r <= ltgl;
      lhs_r <= lhs;
      lvs_r <= lvs;
      if ((ltgl != lprev_r) && lde) begin
        ldat_r <= lpix;
        ltgl_r <= ~ltgl_r;
      end
    end
  end

  // ==========================================================================
  // system clock side: toggle synchronisers; data is stable a full
  // pixel period after its toggle, which is why the word is not synced, only its toggle
  logic [2:0] pt_r, lt_r;
  logic [1:0] vs_r, hs_r, fd_r;
  logic src_r;
  logic [VIP_PW-1:0] src_dat;
  logic src_evt;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pt_r <= '0;
      lt_r <= '0;
      vs_r <= '0;
      hs_r <= '0;
      fd_r <= '0;
    end else begin
      pt_r <= {pt_r[1:0], ptgl_r};
      lt_r <= {lt_r[1:0], ltgl_r};
      vs_r <= {vs_r[0], (src_r ? lvs_r : pvs2_r)};
      hs_r <= {hs_r[0], (src_r ? lhs_r : phs2_r)};
      fd_r <= {fd_r[0], pfld2_r};
    end
  end

  assign src_evt = src_r ? (lt_r[2] != lt_r[1]) : (pt_r[2] != pt_r[1]);
  assign src_dat = src_r ? ldat_r : pdat_r;

  // source select and shared-pin tri-state control
  logic ss_m_r, ps_m_r, ps_r;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ss_m_r <= 1'b0;
      src_r <= 1'b0;
      ps_m_r <= 1'b0;
      ps_r <= 1'b0;
      o_src0_hiz <= 1'b0;
      o_src1_hiz <= 1'b1;
    end else begin
      ss_m_r <= i_src_sel;
      src_r <= ss_m_r;
      ps_m_r <= i_par_src_sel;
      ps_r <= ps_m_r;
      o_src0_hiz <= ps_r; // R5
      o_src1_hiz <= ~ps_r; // R5
    end
  end

  // pixel output and 8.2 integer view of slot 0
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pix <= '0;
      o_pix_vld <= 1'b0;
      o_vs <= 1'b0;
      o_hs <= 1'b0;
      o_field <= 1'b0;
      o_int0 <= '0;
    end else begin
      o_pix_vld <= src_evt; // R12
      o_vs <= vs_r[1];
      o_hs <= hs_r[1];
      o_field <= fd_r[1];
      if (src_evt) begin
        o_pix <= src_dat;
        o_int0 <= src_dat[VIP_CW-1:VIP_FRAC]; // R6
      end
    end
  end

  // ==========================================================================
  // checks
  sequence pix_cap_s;
    src_evt;
  endsequence

  pix_strobe_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    pix_cap_s |=> o_pix_vld) else $error("pixel strobe missing"); // R12
  pix_quiet_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !src_evt |=> !o_pix_vld) else $error("spurious pixel strobe"); // R12
  pix_data_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    pix_cap_s |=> o_pix == $past(src_dat)) else $error("pixel word wrong"); // R12
  fixed_int_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_pix_vld |-> o_int0 == o_pix[VIP_CW-1:VIP_FRAC]) else $error("8.2 integer wrong"); // R6
  hiz_excl_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_src0_hiz != o_src1_hiz) else $error("both sources share drive"); // R5
  hiz_follow_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(ps_r) |=> o_src0_hiz) else $error("tri-state late"); // R5
  remap_a: assert property (@(posedge i_parallel_pixel_clock_a) disable iff (!prst_r)
    pm0_s == VIP_SEL_C |-> pmap_r[VIP_CW-1:0] == pin_r[3*VIP_CW-1:2*VIP_CW])
    else $error("channel remap wrong"); // R4
  cap_a: assert property (@(posedge i_parallel_pixel_clock_a) disable iff (!prst_r)
    pde_r |=> pdat_r == $past(pmap_r) && ptgl_r != $past(ptgl_r))
    else $error("active pixel not held"); // R10
  idle_a: assert property (@(posedge i_parallel_pixel_clock_a) disable iff (!prst_r)
    !pde_r |=> $stable(ptgl_r)) else $error("blank word forwarded"); // R12
  fmt_a: assert property (@(posedge i_lvds_link_clock) disable iff (!lrst_r)
    fmt_s_r == VIP_FMT_2 && u_rx.cnt_r == 3'h6 |=> lpix[2:0] == 3'h0)
    else $error("format demap wrong"); // R8
endmodule

// File: include/vip_pkg.sv
// package for the video input ports: widths, selections, format codes
// ==========================================================================
// How it works
// R1: a source narrower than ten bits per colour lands on the top bits of its channel with low bits tied to zero.
// R2: an eight-bit source drives bits 9:2 of its channel, so the value arrives scaled into the upper bits.
// R3: an embedded-sync component source is 8 or 10 bits wide and sits top-justified on any one channel.
// R4: a configurable remap lets any parallel input channel feed any output colour slot.
// R5: when two sources share the parallel pins the device drives a select that tri-states the idle one.
// R6: each ten-bit channel is an 8.2 fixed-point value, bit n weighing two to the power n minus two.
// R7: the serial flat-panel port carries one channel at an effective pixel clock of at most 90 MHz.
// R8: serial pixel bits are demapped by one of four selectable bit-mapping formats.
// R9: the serial receiver uses one clock pair and five data lanes A to E, all sampled on the link clock.
// R10: sync, enable, field and pixel data of the parallel port are captured on parallel pixel clock A.
// R11: the field input only matters for interlaced sources.
// R12: the parallel port registers its inputs on clock A and forwards only data-enabled words as pixels.
// ==========================================================================
package vip_pkg;
  localparam int VIP_CW = 10;            // bits per colour channel
  localparam int VIP_NCH = 3;            // parallel channels
  localparam int VIP_PW = 30;            // pixel word width
  localparam int VIP_NLANE = 5;          // serial data lanes
  localparam int VIP_SER = 7;            // bits per lane per pixel, one per link clock
  localparam int VIP_FRAC = 2;           // fraction bits of 8.2 value
  localparam int VIP_MAX_MHZ = 90;       // serial effective pixel clock limit
  localparam int VIP_SYS_MHZ = 40;       // system clock rate
  localparam logic [1:0] VIP_SEL_A = 2'h0;
  localparam logic [1:0] VIP_SEL_B = 2'h1;
  localparam logic [1:0] VIP_SEL_C = 2'h2;
  typedef enum logic [1:0] {VIP_FMT_0, VIP_FMT_1, VIP_FMT_2, VIP_FMT_3} vip_fmt_t;
  typedef enum logic {VIP_SRC_PAR, VIP_SRC_SER} vip_src_t;
endpackage

// File: hdl/vip_lvds_rx.sv
// serial flat-panel receiver: lane capture and format demap on the link clock
`timescale 1ns/1ps
module vip_lvds_rx
  import vip_pkg::*;
(
  input wire logic i_lclk,                      // link clock from the source
  input wire logic i_lrst_b,                    // link-domain reset, active low
  input wire logic [VIP_NLANE-1:0] i_lane,      // deserialiser lane bits, one per lane
  input wire logic [1:0] i_fmt,                 // synchronised format select
  output logic [VIP_PW-1:0] o_pix,              // demapped pixel
  output logic o_de,                            // data enable
  output logic o_hs,                            // horizontal sync
  output logic o_vs,                            // vertical sync
  output logic o_tgl                            // toggles once per new pixel
);
  logic [VIP_SER-1:0] sh_r [VIP_NLANE];
  logic [2:0] cnt_r;
  logic [VIP_SER*VIP_NLANE-1:0] w;

  // ==========================================================================
  // lane shift registers, five lanes on the link clock
  genvar g;
  generate
    for (g = 0; g < VIP_NLANE; g++) begin : g_lane
      always_ff @(posedge i_lclk or negedge i_lrst_b) begin
        if (!i_lrst_b) begin
          sh_r[g] <= '0;
        end else begin
          sh_r[g] <= {sh_r[g][VIP_SER-2:0], i_lane[g]}; // R9
        end
      end
      assign w[g*VIP_SER +: VIP_SER] = sh_r[g];
    end
  endgenerate

  // bit counter marks a complete seven-bit slot
  always_ff @(posedge i_lclk or negedge i_lrst_b) begin
    if (!i_lrst_b) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= (cnt_r == 3'(VIP_SER-1)) ? '0 : cnt_r + 3'h1;
    end
  end

  // demap by format; lane order differs, sync bits sit in lane C top bits
  always_ff @(posedge i_lclk or negedge i_lrst_b) begin
    if (!i_lrst_b) begin
      o_pix <= '0;
      o_de <= 1'b0;
      o_hs <= 1'b0;
      o_vs <= 1'b0;
      o_tgl <= 1'b0;
    end else if (cnt_r == 3'(VIP_SER-1)) begin
      o_hs <= w[2*VIP_SER+6];
      o_vs <= w[2*VIP_SER+5];
      o_de <= w[2*VIP_SER+4];
      o_tgl <= ~o_tgl;
      unique case (vip_fmt_t'(i_fmt)) // R8
        VIP_FMT_0: o_pix <= {w[6:0], w[34:32], w[13:7], w[31:29], w[27:21], w[28], w[20:19]};
        VIP_FMT_1: o_pix <= {w[20:14], w[34:32], w[13:7], w[31:29], w[6:0], w[28], w[27:26]};
        VIP_FMT_2: o_pix <= {w[6:0], 3'h0, w[13:7], 3'h0, w[27:21], 3'h0};
        VIP_FMT_3: o_pix <= {w[34:28], w[6:4], w[13:7], w[3:1], w[27:21], w[0], w[20:19]};
      endcase
    end
  end
endmodule

// File: verification/vip_src_model.sv
// behavioural video source: parallel port on clock A and serial link on its own clock
`timescale 1ns/1ps
module vip_src_model
  import vip_pkg::*;
(
  input wire logic i_hiz,                // device asks this source to let go of the pins
  output logic o_pclk,                   // parallel pixel clock A
  output logic o_vs,                     // vertical sync
  output logic o_hs,                     // horizontal sync
  output logic o_de,                     // data enable
  output logic o_fld,                    // field id
  output logic [VIP_CW-1:0] o_a,         // channel A bits
  output logic [VIP_CW-1:0] o_b,         // channel B bits
  output logic [VIP_CW-1:0] o_c,         // channel C bits
  output logic o_lclk,                   // link clock, still outside frames
  output logic [VIP_NLANE-1:0] o_lane    // lanes A..E
);
  logic de_r;
  logic [2:0] syn_r;
  logic [VIP_CW-1:0] a_r;
  logic [VIP_CW-1:0] b_r;
  logic [VIP_CW-1:0] c_r;
  // ==========================================================================
  // shared pins: a released source falls to the pull-down level, never the last value
  assign o_de = i_hiz ? 1'b0 : de_r;
  assign {o_vs, o_hs, o_fld} = i_hiz ? 3'h0 : syn_r;
  assign o_a = i_hiz ? '0 : a_r;
  assign o_b = i_hiz ? '0 : b_r;
  assign o_c = i_hiz ? '0 : c_r;
  // a few edges of both clocks while the device is held in reset
  initial begin
    {o_pclk, o_lclk, de_r, syn_r, a_r, b_r, c_r, o_lane} = '0;
    fork
      repeat (3) begin #40 o_pclk = 1'b1; #40 o_pclk = 1'b0; end
      repeat (3) begin #32 o_lclk = 1'b1; #32 o_lclk = 1'b0; end
    join
  end
  // ==========================================================================
  // one beat of clock A, data set up half a period before the rising edge
  task automatic pword(input logic de, input logic [2:0] syn, input logic [VIP_CW-1:0] a, b, c);
    {de_r, syn_r, a_r, b_r, c_r} = {de, syn, a, b, c};
    #50 o_pclk = 1'b1;
    #50 o_pclk = 1'b0;
  endtask
  // a word then two idle beats so the capture pipeline drains; field is driven with the sync bits
  task automatic par_px(input logic de, input logic [2:0] syn, input logic [VIP_CW-1:0] a, b, c);
    pword(de, syn, a, b, c);
    pword(1'b0, 3'h0, '0, '0, '0);
    pword(1'b0, 3'h0, '0, '0, '0);
  endtask
  // seven slots per lane, top bit first so it ends in the top of the receiver's shift register;
  // 448 ns a pixel stays well under the 90 MHz ceiling
  task automatic ser_px(input logic [6:0] la, lb, lc, ld, le);
    for (int i = 0; i < VIP_SER; i++) begin
      o_lane = {le[VIP_SER-1-i], ld[VIP_SER-1-i], lc[VIP_SER-1-i], lb[VIP_SER-1-i], la[VIP_SER-1-i]};
      #32 o_lclk = 1'b1;
      #32 o_lclk = 1'b0;
    end
    o_lane = '0;
  endtask
  // idle edges after reset release so both capture domains are out of reset;
  // eight link edges line later seven-slot groups up with the receiver's slot counter
  task automatic warm();
    pword(1'b0, 3'h0, '0, '0, '0);
    pword(1'b0, 3'h0, '0, '0, '0);
    repeat (8) begin #32 o_lclk = 1'b1; #32 o_lclk = 1'b0; end
  endtask
endmodule

// File: verification/tb_video_input_ports.sv
// self-checking bench for the video input ports
`timescale 1ns/1ps
module tb_video_input_ports;
  import vip_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [1:0] map0 = 2'h0, map1 = 2'h1, map2 = 2'h2, fmt = 2'h0;
  logic src_sel = 1'b0;
  logic par_sel = 1'b0;
  logic pclk, vs, hs, de, fld, lclk, hiz0, hiz1, vld, o_vs, o_hs, o_fld;
  logic [VIP_CW-1:0] ca, cb, cc;
  logic [VIP_NLANE-1:0] lane;
  logic [VIP_PW-1:0] pix;
  logic [VIP_CW-VIP_FRAC-1:0] int0;
  int err_count = 0;
  int compares = 0;
  initial begin
    forever #12.5 i_clk = ~i_clk;
  end
  vip_top uut(.i_clk(i_clk), .i_rst_b(i_rst_b), .i_parallel_pixel_clock_a(pclk),
    .i_parallel_vertical_sync(vs), .i_parallel_horizontal_sync(hs), .i_parallel_data_enable(de),
    .i_parallel_field_id(fld), .i_chan_a(ca), .i_chan_b(cb), .i_chan_c(cc), .i_lvds_link_clock(lclk),
    .i_lvds_lane(lane), .i_map_0(map0), .i_map_1(map1), .i_map_2(map2), .i_lvds_fmt(fmt),
    .i_src_sel(src_sel), .i_par_src_sel(par_sel), .o_src0_hiz(hiz0), .o_src1_hiz(hiz1), .o_pix(pix),
    .o_pix_vld(vld), .o_vs(o_vs), .o_hs(o_hs), .o_field(o_fld), .o_int0(int0));
  vip_src_model src(.i_hiz(hiz0), .o_pclk(pclk), .o_vs(vs), .o_hs(hs), .o_de(de), .o_fld(fld),
    .o_a(ca), .o_b(cb), .o_c(cc), .o_lclk(lclk), .o_lane(lane));
  // ==========================================================================
  // compares and the closing report
  task automatic chk_bit(input string nm, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic chk_pix(input string nm, input logic [VIP_PW-1:0] exp, input logic [VIP_PW-1:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================================
  // bounded watch for one strobe; sampled mid-cycle where outputs have settled
  task automatic wait_px(output logic got, output logic [VIP_PW-1:0] p, output logic [2:0] s);
    got = 1'b0;
    p = '0;
    s = 3'h0;
    for (int i = 0; i < 90 && !got; i++) begin
      @(negedge i_clk);
      if (vld === 1'b1) begin
        got = 1'b1;
        p = pix;
        s = {o_vs, o_hs, o_fld};
      end
    end
  endtask
  task automatic par_try(input logic d, input logic [2:0] syn, input logic [9:0] a, b, c,
      output logic got, output logic [VIP_PW-1:0] p, output logic [2:0] s);
    fork
      src.par_px(d, syn, a, b, c);
      wait_px(got, p, s);
    join
  endtask
  // leading idle group lets a format change settle, trailing one flushes the link side
  task automatic ser_try(input logic [6:0] la, lb, lc, ld, le, output logic got,
      output logic [VIP_PW-1:0] p, output logic [2:0] s);
    fork
      begin
        src.ser_px('0, '0, '0, '0, '0);
        src.ser_px(la, lb, lc, ld, le);
        src.ser_px('0, '0, '0, '0, '0);
      end
      wait_px(got, p, s);
    join
  endtask
  task automatic set_ctl(input logic [1:0] m0, m1, m2, f, input logic ss, ps);
    @(posedge i_clk);
    map0 <= m0;
    map1 <= m1;
    map2 <= m2;
    fmt <= f;
    src_sel <= ss;
    par_sel <= ps;
    repeat (6) @(posedge i_clk);
    // clock A only runs while the model drives it, so two idle beats carry the map across
    repeat (2) src.pword(1'b0, 3'h0, '0, '0, '0);
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_par();
    logic got;
    logic [VIP_PW-1:0] p;
    logic [2:0] s;
    par_try(1'b1, 3'h7, {8'hA5, 2'h0}, 10'h3FF, 10'h001, got, p, s);
    chk_bit("par strobe", 1'b1, got);
    chk_pix("par pixel", {10'h001, 10'h3FF, 10'h294}, p);
    chk_bit("par vsync", 1'b1, s[2]);
    chk_bit("par hsync", 1'b1, s[1]);
    chk_bit("par field", 1'b1, s[0]);
    chk_pix("integer part", {22'h0, 8'hA5}, {22'h0, int0});
  endtask
  // each map entry puts a different channel in slot 0; code 3 falls back to the default
  task automatic t_remap();
    logic got;
    logic [VIP_PW-1:0] p;
    logic [2:0] s;
    logic [1:0] m [3][3] = '{'{2'h2, 2'h0, 2'h1}, '{2'h1, 2'h2, 2'h0}, '{2'h3, 2'h3, 2'h3}};
    logic [VIP_PW-1:0] e [3] = '{{10'h0F3, 10'h2A8, 10'h35C}, {10'h2A8, 10'h35C, 10'h0F3},
                               {10'h35C, 10'h0F3, 10'h2A8}};
    for (int k = 0; k < 3; k++) begin
      set_ctl(m[k][0], m[k][1], m[k][2], 2'h0, 1'b0, 1'b0);
      par_try(1'b1, 3'h0, 10'h2A8, 10'h0F3, 10'h35C, got, p, s);
      chk_bit("remap strobe", 1'b1, got);
      chk_pix("remap pixel", e[k], p);
      chk_pix("remap integer", {22'h0, e[k][9:2]}, {22'h0, int0});
    end
    set_ctl(2'h0, 2'h1, 2'h2, 2'h0, 1'b0, 1'b0);
  endtask
  task automatic t_refuse();
    logic got;
    logic [VIP_PW-1:0] p;
    logic [2:0] s;
    par_try(1'b0, 3'h0, 10'h155, 10'h155, 10'h155, got, p, s);
    chk_bit("enable low dropped", 1'b0, got);
    set_ctl(2'h0, 2'h1, 2'h2, 2'h0, 1'b0, 1'b1);
    chk_bit("source 0 hiz", 1'b1, hiz0);
    chk_bit("source 1 hiz", 1'b0, hiz1);
    par_try(1'b1, 3'h0, 10'h155, 10'h155, 10'h155, got, p, s);
    chk_bit("released source", 1'b0, got);
    set_ctl(2'h0, 2'h1, 2'h2, 2'h0, 1'b0, 1'b0);
    chk_bit("source 0 back", 1'b0, hiz0);
  endtask
  task automatic t_serial();
    logic got;
    logic [VIP_PW-1:0] p;
    logic [2:0] s;
    for (int f = 0; f < 4; f++) begin
      set_ctl(2'h0, 2'h1, 2'h2, f[1:0], 1'b1, 1'b0);
      ser_try(7'h55, 7'h2A, 7'h50, 7'h63, 7'h19, got, p, s);
      chk_bit("serial strobe", 1'b1, got);
      chk_bit("serial hsync", 1'b1, s[1]);
      chk_bit("serial vsync", 1'b0, s[2]);
      if (f == 2) chk_pix("serial format 2", {7'h55, 3'h0, 7'h2A, 3'h0, 7'h63, 3'h0}, p);
    end
    par_try(1'b1, 3'h0, 10'h3FF, 10'h3FF, 10'h3FF, got, p, s);
    chk_bit("parallel while serial", 1'b0, got);
  endtask
  // main sequence: reset values are looked at while reset is still held
  initial begin
    repeat (15) @(posedge i_clk);
    chk_bit("reset hiz 0", 1'b0, hiz0);
    chk_bit("reset hiz 1", 1'b1, hiz1);
    chk_bit("reset strobe", 1'b0, vld);
    @(posedge i_clk);
    i_rst_b <= 1'b1;
    src.warm();
    t_par();
    t_remap();
    t_refuse();
    t_serial();
    end_sim();
  end
endmodule
